// ==== inc/pml_pkg.sv ====
package pml_pkg;
	localparam int PML_CLK_HZ = 50_000_000;
	localparam int PML_ADR_W = 12;
	// Word indices; byte address is four times the index
	localparam logic [9:0] PML_IDX_LINE_PERIOD_SUM_PER_SECOND = 10'h11d;
	localparam logic [9:0] PML_IDX_LINE_PERIOD_SUM_LONG = 10'h11e;
	localparam logic [9:0] PML_IDX_INST_LINE_PERIOD_COUNT = 10'h19a;
	localparam logic [9:0] PML_IDX_RAW_BASE = 10'h1a0;
	localparam logic [9:0] PML_IDX_INST_BASE = 10'h1a4;
	// Read-write registers, one slot each
	localparam int PML_NUM_RW = 24;
	localparam logic [9:0] PML_SLOT_IDX [PML_NUM_RW] = '{
		10'h119, 10'h11a, 10'h11b, 10'h11c, 10'h11f, 10'h120, 10'h121, 10'h122,
		10'h125, 10'h126, 10'h127, 10'h128, 10'h129, 10'h12a, 10'h12b, 10'h12c,
		10'h12e, 10'h12f, 10'h130, 10'h131, 10'h132, 10'h183, 10'h180, 10'h184};
	localparam int PML_SLOT_COEFF = 8;
	localparam int PML_SLOT_PARAM_ZERO = 21;
	localparam int PML_SLOT_SYS_CTRL = 22;
	localparam int PML_SLOT_PARAM_ONE = 23;
	localparam logic [31:0] PML_COEFF_RST = 32'h811d2ba7;
	localparam logic [31:0] PML_SLOT_RST [PML_NUM_RW] = '{
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		PML_COEFF_RST, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	// Power channels: 0 total active, 1 total reactive, 2 fund active, 3 fund reactive
	localparam int PML_NUM_PWR = 4;
	localparam int PML_AVG_SLOT [PML_NUM_PWR] = '{0, 1, 4, 5};
	localparam int PML_GAIN_SLOT [PML_NUM_PWR] = '{16, 18, 10, 12};
	localparam int PML_OFS_SLOT [PML_NUM_PWR] = '{17, 19, 11, 13};
	// Filter gains in Q16: 0.99985, 0.78402, 0.72585, 0.36292
	localparam logic signed [31:0] PML_FILT_GAIN [PML_NUM_PWR] = '{
		32'sh0000fff6, 32'sh0000c8b6, 32'sh0000b9d1, 32'sh00005ce8};
	// Field positions
	localparam int PML_MEASURE_CLOCK_SELECT_BIT = 1;
	localparam int PML_HIGHPASS_BYPASS_BIT = 20;
	localparam int PML_BANDPASS_SHIFT_LSB = 13;
	localparam int PML_BANDPASS_SHIFT_BASE = 8;
	// Timing
	localparam int PML_REFRESH_FAST_MS = 160;
	localparam int PML_REFRESH_SLOW_MS = 640;
	localparam int PML_AVG_FAST_MS = 1280;
	localparam int PML_AVG_PER_REFRESH = PML_AVG_FAST_MS / PML_REFRESH_FAST_MS;
	localparam int PML_AVG_SHIFT = 3;
	localparam int PML_REFRESH_FAST_CYC = PML_REFRESH_FAST_MS * (PML_CLK_HZ / 1000);
	localparam int PML_REFRESH_SLOW_CYC = PML_REFRESH_SLOW_MS * (PML_CLK_HZ / 1000);
	localparam int PML_LINE_SAMPLE_HZ = 3200;
	localparam int PML_LINE_SAMPLE_CYC = PML_CLK_HZ / PML_LINE_SAMPLE_HZ;
	localparam int PML_PERIODS_PER_SUM = 256;
	localparam int PML_SUMS_PER_LONG = 8;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [PML_ADR_W-1:0] adr;
		logic [31:0] dat;
	} pml_wb_req_s;
endpackage

// ==== logic/pml_power_meter.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - Total active power from unfiltered current times voltage
// - Total reactive power via ninety degree shifted current
// - Fundamental powers from band-pass filtered signals
// - Calibrate: raw times one plus gain, plus offset
// - Store instantaneous, average; 32-bit two's complement
// - Fast clock: refresh 160 ms, settle 500 ms
// - Fast clock: averages refresh 1.28 s, settle 3 s
// - Slow clock: refresh 640 ms, settle 2000 ms
// - Slow clock: averages refresh 5.12 s, settle 12 s
// - Count 3200 Hz samples between rising zero crossings
// - Sum 256 periods into per-second register
// - Sum eight per-second sums into long register
// - Voltage band-pass shift chosen by two-bit field
// - Smaller shift: faster, looser, weaker suppression
// - RMS gain words readable and writable
// - Average RMS and power registers readable and writable
// - One control bit selects the measurement clock
// - High-pass DC removal unless bypass bit set
module pml_power_meter #(
	parameter int SAMPLE_W = 24,
	parameter int REFRESH_FAST_CYC = pml_pkg::PML_REFRESH_FAST_CYC,
	parameter int REFRESH_SLOW_CYC = pml_pkg::PML_REFRESH_SLOW_CYC,
	parameter int LINE_SAMPLE_CYC = pml_pkg::PML_LINE_SAMPLE_CYC,
	parameter int HPF_K = 12,
	parameter int HIL_K = 6,
	parameter int SMOOTH_K = 10
)(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire pml_pkg::pml_wb_req_s wb_req,
	input wire logic signed [SAMPLE_W-1:0] cur_sample,
	input wire logic signed [SAMPLE_W-1:0] volt_sample,
	input wire logic sample_valid,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o
);
	localparam int PROD_SHIFT = 2 * SAMPLE_W - 34;

	function automatic logic [31:0] sat32(input logic signed [63:0] v);
		if (v > 64'sh000000007fffffff)
			sat32 = 32'h7fffffff;
		else if (v < 64'shffffffff80000000)
			sat32 = 32'h80000000;
		else
			sat32 = v[31:0];
	endfunction

	// Register file and bus decode
	logic [31:0] rw_reg [pml_pkg::PML_NUM_RW];
	logic [pml_pkg::PML_NUM_RW-1:0] slot_hit;
	logic [31:0] rd_data;
	logic [31:0] raw_reg [pml_pkg::PML_NUM_PWR];
	logic [31:0] inst_reg [pml_pkg::PML_NUM_PWR];
	logic [31:0] avg_val_reg [pml_pkg::PML_NUM_PWR];
	logic avg_store_reg;
	logic [15:0] period_reg;
	logic [31:0] sum_sec_reg;
	logic [31:0] sum_long_reg;

	// Word-indexed decode; low address bits ignored
	// A request is taken only while no ack stands
	wire bus_access = wb_req.cyc & wb_req.stb & ~wb_ack_o;
	wire bus_wr = bus_access & wb_req.we;
	wire [9:0] word_idx = wb_req.adr[11:2];
	wire [31:0] lane_mask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
		{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
	wire [9:0] pwr_off = word_idx - pml_pkg::PML_IDX_RAW_BASE;
	wire raw_hit = (word_idx >= pml_pkg::PML_IDX_RAW_BASE) & (pwr_off < 10'h004);
	wire inst_hit = (word_idx >= pml_pkg::PML_IDX_INST_BASE) & (pwr_off < 10'h008);
	// Read decode for the measured values
	wire period_hit = word_idx == pml_pkg::PML_IDX_INST_LINE_PERIOD_COUNT;
	wire sec_hit = word_idx == pml_pkg::PML_IDX_LINE_PERIOD_SUM_PER_SECOND;
	wire long_hit = word_idx == pml_pkg::PML_IDX_LINE_PERIOD_SUM_LONG;

	genvar s;
	generate
		for (s = 0; s < pml_pkg::PML_NUM_RW; s++)
		begin : g_slot
			localparam int CH = (s == 0) ? 0 : (s == 1) ? 1 : (s == 4) ? 2 : 3;
			localparam bit IS_AVG = (s == 0) || (s == 1) || (s == 4) || (s == 5);
			assign slot_hit[s] = word_idx == pml_pkg::PML_SLOT_IDX[s];
			// Hardware average store wins over a bus write
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					rw_reg[s] <= pml_pkg::PML_SLOT_RST[s];
				else if (IS_AVG && avg_store_reg)
					rw_reg[s] <= avg_val_reg[CH];
				else if (bus_wr && slot_hit[s])
					rw_reg[s] <= (rw_reg[s] & ~lane_mask) | (wb_req.dat & lane_mask);
			end
		end
	endgenerate

	always_comb
	begin
		// Unmapped addresses read as zero
		rd_data = 32'h0;
		for (int i = 0; i < pml_pkg::PML_NUM_RW; i++)
			if (slot_hit[i])
				rd_data = rw_reg[i];
		if (period_hit)
			rd_data = {16'h0, period_reg};
		else if (sec_hit)
			rd_data = sum_sec_reg;
		else if (long_hit)
			rd_data = sum_long_reg;
		else if (raw_hit)
			rd_data = raw_reg[pwr_off[1:0]];
		else if (inst_hit)
			rd_data = inst_reg[pwr_off[1:0]];
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			// Ack one cycle after the take; read data holds
			wb_ack_o <= bus_access;
			if (bus_access && !wb_req.we)
				wb_dat_o <= rd_data;
		end
	end

	// Configuration
	wire slow_clk = rw_reg[pml_pkg::PML_SLOT_SYS_CTRL][pml_pkg::PML_MEASURE_CLOCK_SELECT_BIT];
	wire hpf_bypass = rw_reg[pml_pkg::PML_SLOT_PARAM_ONE][pml_pkg::PML_HIGHPASS_BYPASS_BIT];
	wire [1:0] shift_sel = rw_reg[pml_pkg::PML_SLOT_PARAM_ZERO][pml_pkg::PML_BANDPASS_SHIFT_LSB +: 2];
	wire [4:0] bp_shift = 5'(pml_pkg::PML_BANDPASS_SHIFT_BASE) + {3'h0, shift_sel};
	wire signed [31:0] bp_coeff = rw_reg[pml_pkg::PML_SLOT_COEFF];

	// Refresh timing
	// Average store follows the eighth tick by one cycle
	logic [31:0] refresh_cnt_reg;
	logic [2:0] avg_cnt_reg;
	// Slow measurement clock stretches the interval
	wire [31:0] refresh_lim = slow_clk ? 32'(REFRESH_SLOW_CYC) : 32'(REFRESH_FAST_CYC);
	wire refresh_hit = refresh_cnt_reg >= refresh_lim - 32'h1;
	wire avg_hit = refresh_hit && avg_cnt_reg == 3'(pml_pkg::PML_AVG_PER_REFRESH - 1);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			refresh_cnt_reg <= 32'h0;
			avg_cnt_reg <= 3'h0;
			avg_store_reg <= 1'b0;
		end
		else
		begin
			refresh_cnt_reg <= refresh_hit ? 32'h0 : refresh_cnt_reg + 32'h1;
			if (refresh_hit)
				avg_cnt_reg <= avg_cnt_reg + 3'h1;
			avg_store_reg <= avg_hit;
		end
	end

	// Front end: DC removal, band-pass, ninety degree shift
	logic signed [31:0] ac_reg [2];
	logic signed [31:0] fund_reg [2];
	logic signed [31:0] hil_reg [2];
	logic sv_d_reg;

	// Channel 0 current, channel 1 voltage
	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_chan
			// Slow DC tracker for the high-pass
			logic signed [31:0] dc_reg;
			logic signed [31:0] x1_reg;
			logic signed [31:0] x2_reg;
			logic signed [31:0] y2_reg;
			wire signed [31:0] x_in = (c == 0) ? 32'(cur_sample) : 32'(volt_sample);
			wire signed [31:0] ac_w = hpf_bypass ? x_in : x_in - dc_reg;
			wire signed [63:0] fb_w = 64'(bp_coeff) * 64'(fund_reg[c]);
			// Resonator; a smaller shift widens the band and speeds response
			wire signed [31:0] y_w = ((ac_w - x2_reg) >>> bp_shift) - 32'(fb_w >>> 30)
				- y2_reg + (y2_reg >>> bp_shift);
			wire signed [31:0] h_in = (c == 0) ? ac_w : y_w;
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					dc_reg <= 32'sh0;
					x1_reg <= 32'sh0;
					x2_reg <= 32'sh0;
					y2_reg <= 32'sh0;
					ac_reg[c] <= 32'sh0;
					fund_reg[c] <= 32'sh0;
					hil_reg[c] <= 32'sh0;
				end
				else if (sample_valid)
				begin
					dc_reg <= dc_reg + ((x_in - dc_reg) >>> HPF_K);
					x1_reg <= ac_w;
					x2_reg <= x1_reg;
					y2_reg <= fund_reg[c];
					ac_reg[c] <= ac_w;
					fund_reg[c] <= y_w;
					// Low corner lag: about ninety degrees at line rate
					hil_reg[c] <= hil_reg[c] + ((h_in - hil_reg[c]) >>> HIL_K);
				end
			end
		end
	endgenerate

	// Product stage runs one cycle after the filters
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			sv_d_reg <= 1'b0;
		else
			sv_d_reg <= sample_valid;
	end

	// Power channels
	// Order: total P, total Q, fund P, fund Q
	genvar k;
	generate
		for (k = 0; k < pml_pkg::PML_NUM_PWR; k++)
		begin : g_pwr
			logic signed [63:0] sm_reg;
			logic signed [63:0] acc_reg;
			// Total reactive: shifted current times voltage
			wire signed [31:0] a_w = (k == 0) ? ac_reg[0] : (k == 1) ? hil_reg[0] : fund_reg[0];
			wire signed [31:0] b_w = (k < 2) ? ac_reg[1] : (k == 2) ? fund_reg[1] : hil_reg[1];
			wire signed [63:0] prod_w = 64'(a_w) * 64'(b_w);
			wire signed [63:0] scaled_w = (sm_reg * 64'(pml_pkg::PML_FILT_GAIN[k])) >>> 16;
			wire signed [31:0] raw_w = sat32(scaled_w);
			// Calibration, then saturation to 32 bits
			wire signed [31:0] gain_w = rw_reg[pml_pkg::PML_GAIN_SLOT[k]];
			wire signed [31:0] ofs_w = rw_reg[pml_pkg::PML_OFS_SLOT[k]];
			wire signed [63:0] cal_w = 64'(raw_w) + ((64'(raw_w) * 64'(gain_w)) >>> 31)
				+ 64'(ofs_w);
			wire signed [31:0] inst_w = sat32(cal_w);
			wire signed [63:0] sum_w = acc_reg + 64'(inst_w);
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					sm_reg <= 64'sh0;
					acc_reg <= 64'sh0;
					raw_reg[k] <= 32'h0;
					inst_reg[k] <= 32'h0;
					avg_val_reg[k] <= 32'h0;
				end
				else
				begin
					if (sv_d_reg)
						sm_reg <= sm_reg + (((prod_w >>> PROD_SHIFT) - sm_reg) >>> SMOOTH_K);
					// Raw and instantaneous latched at each tick
					if (refresh_hit)
					begin
						raw_reg[k] <= raw_w;
						inst_reg[k] <= inst_w;
						acc_reg <= avg_hit ? 64'sh0 : sum_w;
						// Mean of eight values by shift
						if (avg_hit)
							avg_val_reg[k] <= sat32(sum_w >>> pml_pkg::PML_AVG_SHIFT);
					end
				end
			end
		end
	endgenerate

	// Line period measurement on the fundamental voltage
	logic [15:0] ls_cnt_reg;
	logic neg_prev_reg;
	logic armed_reg;
	logic [15:0] per_cnt_reg;
	logic new_period_reg;
	logic [31:0] sum256_reg;
	logic [7:0] n256_reg;
	logic new_sec_reg;
	logic [31:0] sum8_reg;
	logic [2:0] n8_reg;
	wire ls_hit = ls_cnt_reg == 16'(LINE_SAMPLE_CYC - 1);
	wire rising = ls_hit & neg_prev_reg & ~fund_reg[1][31];
	wire [31:0] sum256_w = sum256_reg + {16'h0, period_reg};
	wire [31:0] sum8_w = sum8_reg + sum_sec_reg;
	// Saturating period count and the two sum counters
	wire per_full = per_cnt_reg == 16'hffff;
	wire sec_full = n256_reg == 8'(pml_pkg::PML_PERIODS_PER_SUM - 1);
	wire long_full = n8_reg == 3'(pml_pkg::PML_SUMS_PER_LONG - 1);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ls_cnt_reg <= 16'h0;
			neg_prev_reg <= 1'b0;
			armed_reg <= 1'b0;
			per_cnt_reg <= 16'h0;
			period_reg <= 16'h0;
			new_period_reg <= 1'b0;
		end
		else
		begin
			ls_cnt_reg <= ls_hit ? 16'h0 : ls_cnt_reg + 16'h1;
			new_period_reg <= rising & armed_reg;
			if (ls_hit)
			begin
				neg_prev_reg <= fund_reg[1][31];
				// First crossing only arms the counter
				if (rising)
				begin
					per_cnt_reg <= 16'h0;
					armed_reg <= 1'b1;
					if (armed_reg)
						period_reg <= per_cnt_reg + 16'h1;
				end
				// Count stops at all ones
				else if (!per_full)
					per_cnt_reg <= per_cnt_reg + 16'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sum256_reg <= 32'h0;
			n256_reg <= 8'h0;
			sum_sec_reg <= 32'h0;
			new_sec_reg <= 1'b0;
			sum8_reg <= 32'h0;
			n8_reg <= 3'h0;
			sum_long_reg <= 32'h0;
		end
		else
		begin
			// Per-second sum every 256 periods, long sum every eight
			new_sec_reg <= new_period_reg && sec_full;
			if (new_period_reg)
			begin
				n256_reg <= n256_reg + 8'h1;
				if (sec_full)
				begin
					sum_sec_reg <= sum256_w;
					sum256_reg <= 32'h0;
				end
				else
					sum256_reg <= sum256_w;
			end
			if (new_sec_reg)
			begin
				n8_reg <= n8_reg + 3'h1;
				if (long_full)
				begin
					sum_long_reg <= sum8_w;
					sum8_reg <= 32'h0;
				end
				else
					sum8_reg <= sum8_w;
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/pml_power_meter_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module pml_power_meter_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire pml_pkg::pml_wb_req_s wb_req,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o
);
	wire logic take;
	wire logic rd_take;
	wire logic unmapped;
	assign take = wb_req.cyc & wb_req.stb & ~wb_ack_o;
	assign rd_take = take & ~wb_req.we;
	assign unmapped = wb_req.adr[11:2] < 10'h119;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// Full-word write, then read, of the total active power gain word
	sequence s_wr_gain;
		take && wb_req.we && wb_req.adr == 12'h4b8 && wb_req.sel == 4'hf;
	endsequence
	sequence s_rd_gain;
		rd_take && wb_req.adr == 12'h4b8;
	endsequence
	AST_ACK_NEXT: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	AST_ACK_WITHIN: assert property (wb_req.cyc && wb_req.stb |-> ##[0:1] wb_ack_o)
		else $error("request not answered");
	AST_DAT_HOLD: assert property (!rd_take |=> $stable(wb_dat_o))
		else $error("read data changed without read");
	AST_UNMAPPED_ZERO: assert property (rd_take && unmapped |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_RESET_QUIET: assert property ($rose(nrst) |-> !wb_ack_o && wb_dat_o == 32'h0)
		else $error("bus outputs busy after reset");
	AST_GAIN_READBACK: assert property (s_wr_gain ##3 s_rd_gain |=> wb_dat_o == $past(wb_req.dat, 4))
		else $error("gain word readback wrong");
endmodule
bind pml_power_meter pml_power_meter_chk chk_u (.ref_clk(ref_clk), .nrst(nrst), .wb_req(wb_req),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
`default_nettype wire

// ==== bench/pml_power_meter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ev, got) begin checks++; if ((got) !== (ev)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, ev, got); end end
module pml_power_meter_tb;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	pml_pkg::pml_wb_req_s wb_req = '0;
	logic signed [23:0] cur_sample = '0;
	logic signed [23:0] volt_sample = '0;
	logic sample_valid = 1'b0;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	logic [1:0] div = 2'h0;
	int n_fail = 0;
	int checks = 0;
	pml_power_meter #(.REFRESH_FAST_CYC(200), .REFRESH_SLOW_CYC(800), .LINE_SAMPLE_CYC(20)) dut_u (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.wb_req(wb_req),
		.cur_sample(cur_sample),
		.volt_sample(volt_sample),
		.sample_valid(sample_valid),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o)
	);
	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end
	// Sample pulse every fourth cycle
	always @(posedge ref_clk)
	begin
		div <= div + 2'h1;
		sample_valid <= (div == 2'h0);
	end
	task automatic bus(input logic we, input logic [9:0] idx, input logic [31:0] d,
		input logic [3:0] sel, output logic [31:0] q);
		@(posedge ref_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: {idx, 2'b00}, dat: d};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_req <= '0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] q;
		bus(1'b1, idx, d, sel, q);
	endtask
	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] ev, input string nm);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, 4'hf, q);
		`CHK(nm, ev, q)
	endtask
	task automatic t_reset_values();
		rd_chk(10'h125, pml_pkg::PML_COEFF_RST, "coeff");
		rd_chk(10'h12e, 32'h0, "gain");
		rd_chk(10'h183, 32'h0, "param zero");
	endtask
	task automatic t_rw_words();
		logic [9:0] idx [8];
		idx = '{10'h11b, 10'h11c, 10'h121, 10'h122, 10'h126, 10'h12b, 10'h12c, 10'h132};
		foreach (idx[k])
			wr(idx[k], {22'h16a5a5, idx[k]}, 4'hf);
		foreach (idx[k])
			rd_chk(idx[k], {22'h16a5a5, idx[k]}, "rw word");
		// Byte lane merge
		wr(10'h12c, 32'hffffffff, 4'h2);
		rd_chk(10'h12c, {16'h5a96, 8'hff, 8'h2c}, "lane merge");
	endtask
	task automatic t_ro_unmapped();
		wr(10'h11d, 32'h12345678, 4'hf);
		rd_chk(10'h11d, 32'h0, "sum per second");
		wr(10'h11e, 32'h12345678, 4'hf);
		rd_chk(10'h11e, 32'h0, "sum long");
		wr(10'h19a, 32'h00001111, 4'hf);
		rd_chk(10'h19a, 32'h0, "inst period");
		wr(10'h100, 32'hdeadbeef, 4'hf);
		rd_chk(10'h100, 32'h0, "unmapped");
	endtask
	task automatic t_offset_cal();
		wr(10'h12e, 32'h40000000, 4'hf);
		rd_chk(10'h12e, 32'h40000000, "gain back");
		wr(10'h12f, 32'h00001234, 4'hf);
		wr(10'h12a, 32'hfffffff0, 4'hf);
		repeat (210) @(posedge ref_clk);
		rd_chk(10'h1a0, 32'h0, "raw total p");
		rd_chk(10'h1a1, 32'h0, "raw total q");
		rd_chk(10'h1a3, 32'h0, "raw fund q");
		rd_chk(10'h1a4, 32'h00001234, "inst total p");
		rd_chk(10'h1a7, 32'hfffffff0, "inst fund q");
		repeat (1900) @(posedge ref_clk);
		rd_chk(10'h119, 32'h00001234, "avg total p");
		rd_chk(10'h120, 32'hfffffff0, "avg fund q");
	endtask
	task automatic t_slow_refresh();
		logic [31:0] q;
		longint t1;
		int d;
		wr(10'h180, 32'h00000002, 4'hf);
		wr(10'h12f, 32'h00000aaa, 4'hf);
		do bus(1'b0, 10'h1a4, 32'h0, 4'hf, q); while (q !== 32'h00000aaa);
		t1 = $time;
		wr(10'h12f, 32'h00000555, 4'hf);
		do bus(1'b0, 10'h1a4, 32'h0, 4'hf, q); while (q !== 32'h00000555);
		d = int'(($time - t1) / 20);
		`CHK("slow refresh cycles", 1'b1, (d >= 796 && d <= 804))
		wr(10'h180, 32'h0, 4'hf);
	endtask
	task automatic t_dc_power();
		logic [31:0] q;
		wr(10'h184, 32'h00100000, 4'hf);
		wr(10'h12f, 32'h80000000, 4'hf);
		cur_sample <= 24'sh100000;
		volt_sample <= 24'shf00000;
		repeat (1500) @(posedge ref_clk);
		bus(1'b0, 10'h1a0, 32'h0, 4'hf, q);
		`CHK("raw total p sign", 2'h2, ({q[31], q == 32'h0}))
		bus(1'b0, 10'h1a1, 32'h0, 4'hf, q);
		`CHK("raw total q sign", 2'h2, ({q[31], q == 32'h0}))
		rd_chk(10'h1a4, 32'h80000000, "inst total p sat");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset_values();
		t_rw_words();
		t_ro_unmapped();
		t_offset_cal();
		t_slow_refresh();
		t_dc_power();
		tally_and_finish();
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
